// [src/pfc_pwm_timing.sv]
// Purpose: Correction PWM timing with AXI4-Lite registers
// Assumes: Single clock; ac_peak comes from logic on this clock
// Notes: Gatekill pin is synchronised before use
`timescale 1ns/1ns
`default_nettype none
module pfc_pwm_timing
    import pfc_pkg::*;
#(
    parameter int unsigned REF_CYCLES = REF_UPDATE_CYCLES  // Bus reference update interval
)(
    input wire logic clk,                 // 100 MHz clock
    input wire logic rst_b,               // Synchronous reset, active low
    input wire logic [ADDR_W-1:0] awaddr, // Write address
    input wire logic awvalid,             // Write address valid
    output logic awready,                 // Write address ready
    input wire logic [31:0] wdata,        // Write data
    input wire logic [3:0] wstrb,         // Write byte enables
    input wire logic wvalid,              // Write data valid
    output logic wready,                  // Write data ready
    output logic [1:0] bresp,             // Write response
    output logic bvalid,                  // Write response valid
    input wire logic bready,              // Write response ready
    input wire logic [ADDR_W-1:0] araddr, // Read address
    input wire logic arvalid,             // Read address valid
    output logic arready,                 // Read address ready
    output logic [31:0] rdata,            // Read data
    output logic [1:0] rresp,             // Read response
    output logic rvalid,                  // Read data valid
    input wire logic rready,              // Read data ready
    input wire logic gatekill_in,         // Over-current fault pin
    input wire logic [15:0] ac_peak,      // Measured AC peak voltage
    output logic pwm_out,                 // Correction switch drive
    output logic sample_trig,             // Inductor current sample pulse
    output logic loop_start,              // Control loop start pulse
    output logic [15:0] dc_bus_ref        // Active bus voltage reference
);
    pwm_link_if lnk();

    logic [31:0] mcw_reg;
    logic [15:0] period_reg;
    logic [15:0] duty_reg;
    logic partial_reg;
    logic run_reg;
    logic [15:0] hyst_reg;
    logic [15:0] vref_reg;
    logic [15:0] period_applied_reg;
    logic apply_pending_reg;
    logic configured_reg;
    logic strobe_seen_reg;
    logic fault_reg;
    logic gk_meta_reg;
    logic gk_sync_reg;
    logic [REF_CNT_W-1:0] ref_cnt_reg;
    logic [15:0] bus_ref_reg;
    logic aw_held_reg;
    logic w_held_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic do_write;
    logic ref_tick;
    logic clr_strobe;
    logic clr_fault;

    // ----------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------
    // Byte-lane merge used by the MCW, PERIOD, DUTY, HYST and VREF writes
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Unknown ratio codes fall back to two; period floored at two
    function automatic logic [15:0] corr_period(input logic [15:0] mp, input logic [2:0] code);
        logic [15:0] p;
        unique case (code)
            3'h3: p = mp / 16'h0003;
            3'h4: p = mp / 16'h0004;
            3'h5: p = mp / 16'h0005;
            default: p = mp / 16'h0002;
        endcase
        return (p < MIN_PERIOD) ? MIN_PERIOD : p;
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        return a[1:0] == 2'h0 && a <= OFF_BUSREF;
    endfunction

    // ----------------------------------------------------------
    // AXI4-Lite write path
    // ----------------------------------------------------------
    assign awready = !aw_held_reg && !bvalid_reg;
    assign wready = !w_held_reg && !bvalid_reg;
    assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;

    // Address and data taken in either order, response after both
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg <= awaddr;
            end
            if (wvalid && wready) begin
                w_held_reg <= 1'b1;
                wdata_reg <= wdata;
                wstrb_reg <= wstrb;
            end
            if (do_write) begin
                aw_held_reg <= 1'b0;
                w_held_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_reg && bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;

    // ----------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mcw_reg <= MCW_RST;
            period_reg <= PERIOD_RST;
            duty_reg <= DUTY_RST;
            partial_reg <= 1'b0;
            run_reg <= 1'b0;
            hyst_reg <= HYST_RST;
            vref_reg <= VREF_RST;
        end else if (do_write) begin
            unique case (awaddr_reg)
                OFF_MCW: mcw_reg <= merge(mcw_reg, wdata_reg, wstrb_reg);
                OFF_PERIOD: period_reg <= 16'(merge({16'h0000, period_reg}, wdata_reg,
                                                    wstrb_reg));
                OFF_DUTY: duty_reg <= 16'(merge({16'h0000, duty_reg}, wdata_reg,
                                                wstrb_reg));
                OFF_MODE: begin
                    if (wstrb_reg[0]) begin
                        partial_reg <= wdata_reg[MODE_PARTIAL_BIT];
                        run_reg <= wdata_reg[MODE_RUN_BIT];
                    end
                end
                OFF_HYST: hyst_reg <= 16'(merge({16'h0000, hyst_reg}, wdata_reg, wstrb_reg));
                OFF_VREF: vref_reg <= 16'(merge({16'h0000, vref_reg}, wdata_reg, wstrb_reg));
                default: ;
            endcase
        end
    end

    // Rate reload only at first configuration or precharge end
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            apply_pending_reg <= 1'b0;
            configured_reg <= 1'b0;
            period_applied_reg <= corr_period(PERIOD_RST, MCW_RST[MCW_RATIO_MSB:MCW_RATIO_LSB]);
        end else begin
            apply_pending_reg <= do_write && ((awaddr_reg == OFF_MCW && !configured_reg)
                || (awaddr_reg == OFF_MODE && wstrb_reg[0]
                    && wdata_reg[MODE_PRECHARGE_BIT]));
            if (do_write && awaddr_reg == OFF_MCW) begin
                configured_reg <= 1'b1;
            end
            if (apply_pending_reg) begin
                period_applied_reg <= corr_period(period_reg,
                    mcw_reg[MCW_RATIO_MSB:MCW_RATIO_LSB]);
            end
        end
    end

    // ----------------------------------------------------------
    // Fault and event flags
    // ----------------------------------------------------------
    // Two-stage synchroniser; only the second stage is read
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            gk_meta_reg <= 1'b0;
            gk_sync_reg <= 1'b0;
        end else begin
            gk_meta_reg <= gatekill_in;
            gk_sync_reg <= gk_meta_reg;
        end
    end

    assign clr_strobe = do_write && awaddr_reg == OFF_STATUS && wstrb_reg[0]
                        && wdata_reg[STAT_STROBE_BIT];
    assign clr_fault = do_write && awaddr_reg == OFF_STATUS && wstrb_reg[0]
                       && wdata_reg[STAT_FAULT_BIT];

    // Sticky flags; a new event beats a same-cycle clear
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            fault_reg <= 1'b0;
            strobe_seen_reg <= 1'b0;
        end else begin
            fault_reg <= gk_sync_reg || (fault_reg && !clr_fault);
            strobe_seen_reg <= lnk.strobe || (strobe_seen_reg && !clr_strobe);
        end
    end

    // ----------------------------------------------------------
    // Bus voltage reference
    // ----------------------------------------------------------
    assign ref_tick = ref_cnt_reg == REF_CNT_W'(REF_CYCLES - 1);

    always_ff @(posedge clk) begin
        if (!rst_b || ref_tick || !partial_reg) begin
            ref_cnt_reg <= '0;
        end else begin
            ref_cnt_reg <= ref_cnt_reg + REF_CNT_W'(1);
        end
    end

    // Same scaling on both feedbacks, so plain subtraction
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            bus_ref_reg <= VREF_RST;
        end else if (!partial_reg) begin
            bus_ref_reg <= vref_reg;
        end else if (ref_tick) begin
            bus_ref_reg <= (ac_peak > hyst_reg) ? ac_peak - hyst_reg : 16'h0000;
        end
    end

    // ----------------------------------------------------------
    // AXI4-Lite read path
    // ----------------------------------------------------------
    assign arready = !rvalid_reg;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (araddr)
                OFF_MCW: rdata_reg <= mcw_reg;
                OFF_PERIOD: rdata_reg <= {16'h0000, period_reg};
                OFF_DUTY: rdata_reg <= {16'h0000, duty_reg};
                OFF_MODE: rdata_reg <= {29'h0000_0000, run_reg, 1'b0, partial_reg};
                OFF_HYST: rdata_reg <= {16'h0000, hyst_reg};
                OFF_VREF: rdata_reg <= {16'h0000, vref_reg};
                OFF_STATUS: rdata_reg <= {period_applied_reg, 12'h000, configured_reg,
                                          lnk.pwm, fault_reg, strobe_seen_reg};
                OFF_BUSREF: rdata_reg <= {16'h0000, bus_ref_reg};
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end else if (rvalid_reg && rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;

    // ----------------------------------------------------------
    // PWM core and outputs
    // ----------------------------------------------------------
    assign lnk.run = run_reg;
    assign lnk.fault = fault_reg;
    assign lnk.period = period_applied_reg;
    assign lnk.duty_pending = duty_reg;

    pfc_pwm_core u_core (
        .clk(clk),
        .rst_b(rst_b),
        .lnk(lnk)
    );

    assign pwm_out = lnk.pwm;
    assign sample_trig = lnk.sample;
    assign loop_start = lnk.strobe;
    assign dc_bus_ref = bus_ref_reg;

    // ----------------------------------------------------------
    // Checks
    // ----------------------------------------------------------
    property p_gatekill;
        @(posedge clk) disable iff (!rst_b)
        gatekill_in [*4] |=> !pwm_out && fault_reg;
    endproperty
    a_gatekill: assert property (p_gatekill) else $error("switch on during gatekill");

    property p_rate;
        @(posedge clk) disable iff (!rst_b)
        $changed(period_applied_reg) |-> $past(apply_pending_reg);
    endproperty
    a_rate: assert property (p_rate) else $error("rate changed outside reload");

    property p_full_ref;
        @(posedge clk) disable iff (!rst_b)
        !partial_reg |=> dc_bus_ref == $past(vref_reg);
    endproperty
    a_full_ref: assert property (p_full_ref) else $error("full mode reference wrong");

    property p_partial_ref;
        @(posedge clk) disable iff (!rst_b)
        (partial_reg && ref_tick && ac_peak > hyst_reg) |=> dc_bus_ref == $past(ac_peak)
            - $past(hyst_reg);
    endproperty
    a_partial_ref: assert property (p_partial_ref) else $error("partial reference wrong");

    property p_ref_hold;
        @(posedge clk) disable iff (!rst_b)
        (partial_reg && !ref_tick) |=> $stable(dc_bus_ref);
    endproperty
    a_ref_hold: assert property (p_ref_hold) else $error("reference moved between ticks");

    c_fault: cover property (@(posedge clk) disable iff (!rst_b) $rose(fault_reg));
    c_reload: cover property (@(posedge clk) disable iff (!rst_b) apply_pending_reg);
    c_partial: cover property (@(posedge clk) disable iff (!rst_b) partial_reg && ref_tick);
endmodule
`default_nettype wire

// [src/pfc_pkg.sv]
// Purpose: Shared constants for the correction PWM timing block
// Assumes: 100 MHz clock, 32-bit AXI4-Lite register bus
// Notes: Offsets are byte addresses of aligned 32-bit words
package pfc_pkg;
    // ----------------------------------------------------------
    // Register map
    // ----------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFF_MCW = 8'h00;    // Motor control word
    localparam logic [ADDR_W-1:0] OFF_PERIOD = 8'h04; // Motor period setting
    localparam logic [ADDR_W-1:0] OFF_DUTY = 8'h08;   // Duty command from loop
    localparam logic [ADDR_W-1:0] OFF_MODE = 8'h0C;   // Run, partial, precharge
    localparam logic [ADDR_W-1:0] OFF_HYST = 8'h10;   // Partial-mode gap
    localparam logic [ADDR_W-1:0] OFF_VREF = 8'h14;   // Full-mode bus reference
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h18; // Status, W1C flags
    localparam logic [ADDR_W-1:0] OFF_BUSREF = 8'h1C; // Active bus reference
    // ----------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------
    localparam int MCW_RATIO_LSB = 6;
    localparam int MCW_RATIO_MSB = 8;
    localparam int MODE_PARTIAL_BIT = 0;
    localparam int MODE_PRECHARGE_BIT = 1;
    localparam int MODE_RUN_BIT = 2;
    localparam int STAT_STROBE_BIT = 0;
    localparam int STAT_FAULT_BIT = 1;
    localparam int STAT_PWM_BIT = 2;
    localparam int STAT_CONFIG_BIT = 3;
    // ----------------------------------------------------------
    // Reset values and limits
    // ----------------------------------------------------------
    localparam logic [31:0] MCW_RST = 32'h0000_0080;  // Ratio code 2
    localparam logic [15:0] PERIOD_RST = 16'h1388;
    localparam logic [15:0] DUTY_RST = 16'h0000;
    localparam logic [15:0] HYST_RST = 16'h0000;
    localparam logic [15:0] VREF_RST = 16'h0000;
    localparam logic [15:0] MIN_PERIOD = 16'h0002;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ----------------------------------------------------------
    // Timing
    // ----------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned REF_UPDATE_MS = 100;
    localparam int unsigned REF_UPDATE_CYCLES = REF_UPDATE_MS * 1000000 / CLK_PERIOD_NS;
    localparam int REF_CNT_W = 24;
endpackage

// [src/pwm_link_if.sv]
// Purpose: Carrier between register side and PWM core
// Assumes: Both ends on the same clock
// Notes: No clocking block; plain nets only
`timescale 1ns/1ns
`default_nettype none
interface pwm_link_if;
    logic run;
    logic fault;
    logic [15:0] period;
    logic [15:0] duty_pending;
    logic strobe;
    logic [15:0] duty_latched;
    logic [15:0] count;
    logic pwm;
    logic sample;
    modport ctl(output run, fault, period, duty_pending,
                input strobe, duty_latched, count, pwm, sample);
    modport core(input run, fault, period, duty_pending,
                 output strobe, duty_latched, count, pwm, sample);
endinterface
`default_nettype wire

// [src/pfc_pwm_core.sv]
// Purpose: Carrier counter, strobe, duty latch, compare, sample trigger
// Assumes: period never below two, fault already synchronised
// Notes: All outputs are registered
`timescale 1ns/1ns
`default_nettype none
module pfc_pwm_core
    import pfc_pkg::*;
(
    input wire logic clk,     // 100 MHz clock
    input wire logic rst_b,   // Synchronous reset, active low
    pwm_link_if.core lnk      // Link to register side
);
    logic [15:0] count_reg;
    logic [15:0] duty_latched_reg;
    logic strobe_reg;
    logic pwm_reg;
    logic sample_reg;
    logic wrap;
    logic [15:0] on_len;
    logic [15:0] mid;

    // ----------------------------------------------------------
    // Period end and on-pulse midpoint
    // ----------------------------------------------------------
    // Compare with >= so a shrunk period cannot strand the counter
    assign wrap = count_reg >= (lnk.period - 16'h0001);
    assign on_len = (duty_latched_reg > lnk.period) ? lnk.period : duty_latched_reg;
    assign mid = on_len >> 1;

    // Carrier restarts at every period start
    always_ff @(posedge clk) begin
        if (!rst_b || !lnk.run || wrap) begin
            count_reg <= 16'h0000;
        end else begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    // Strobe at each period boundary starts the loop
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            strobe_reg <= 1'b0;
        end else begin
            strobe_reg <= lnk.run && wrap;
        end
    end

    // New duty taken only on the strobe edge
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            duty_latched_reg <= DUTY_RST;
        end else if (lnk.run && wrap) begin
            duty_latched_reg <= lnk.duty_pending;
        end
    end

    // Switch drive; fault overrides the compare
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pwm_reg <= 1'b0;
        end else begin
            pwm_reg <= lnk.run && !lnk.fault && (duty_latched_reg > count_reg);
        end
    end

    // Current sample in the middle of the on-pulse
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sample_reg <= 1'b0;
        end else begin
            sample_reg <= lnk.run && !lnk.fault && (on_len != 16'h0000)
                          && (count_reg == mid);
        end
    end

    assign lnk.strobe = strobe_reg;
    assign lnk.duty_latched = duty_latched_reg;
    assign lnk.count = count_reg;
    assign lnk.pwm = pwm_reg;
    assign lnk.sample = sample_reg;

    // ----------------------------------------------------------
    // Checks
    // ----------------------------------------------------------
    property p_wrap;
        @(posedge clk) disable iff (!rst_b)
        (lnk.run && wrap) |=> (count_reg == 16'h0000) && strobe_reg;
    endproperty
    a_wrap: assert property (p_wrap) else $error("carrier did not restart with strobe");

    property p_latch;
        @(posedge clk) disable iff (!rst_b)
        $changed(duty_latched_reg) |-> strobe_reg;
    endproperty
    a_latch: assert property (p_latch) else $error("duty changed off the strobe");

    property p_cmp;
        @(posedge clk) disable iff (!rst_b)
        (lnk.run && !lnk.fault) |=> (pwm_reg == ($past(duty_latched_reg) > $past(count_reg)));
    endproperty
    a_cmp: assert property (p_cmp) else $error("switch not equal to compare");

    property p_mid;
        @(posedge clk) disable iff (!rst_b)
        sample_reg |-> $past(count_reg) == ($past(on_len) >> 1);
    endproperty
    a_mid: assert property (p_mid) else $error("sample not at pulse midpoint");

    c_strobe: cover property (@(posedge clk) disable iff (!rst_b) strobe_reg ##[1:200] strobe_reg);
    c_sample: cover property (@(posedge clk) disable iff (!rst_b) sample_reg);
endmodule
`default_nettype wire

// [dv/pfc_pwm_timing_tb.sv]
// Purpose: Self-checking bench for the correction PWM timing block
// Assumes: Bus reference interval shortened to 50 cycles
// Notes: Drives AXI4-Lite directly, no separate partner model
`timescale 1ns/1ns
`default_nettype none
module pfc_pwm_timing_tb;
    import pfc_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, gatekill_in = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, d;
    logic [3:0] wstrb = 4'hf;
    logic [15:0] ac_peak = 16'h0000;
    logic awready, wready, bvalid, arready, rvalid, pwm_out, sample_trig, loop_start;
    logic [1:0] bresp, rresp, r;
    logic [31:0] rdata;
    logic [15:0] dc_bus_ref;
    int bad_count = 0, compares = 0, ns, np, nt;
    // ----------------------------------------
    // Clock, device under test
    // ----------------------------------------
    always #5 clk = ~clk;
    pfc_pwm_timing #(.REF_CYCLES(50)) DUT (.clk(clk), .rst_b(rst_b), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .gatekill_in(gatekill_in), .ac_peak(ac_peak), .pwm_out(pwm_out),
        .sample_trig(sample_trig), .loop_start(loop_start), .dc_bus_ref(dc_bus_ref));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Each half released on its own edge; response held until bvalid seen
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata; r = rresp; rready <= 1'b0;
        @(posedge clk);
    endtask
    // Counts strobes, switch-on cycles and sample pulses over n cycles
    task automatic tally(input int n);
        ns = 0; np = 0; nt = 0;
        repeat (n) begin
            @(posedge clk);
            ns += loop_start; np += pwm_out; nt += sample_trig;
        end
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_rate;
        wr(OFF_PERIOD, 32'h0000_0010);
        wr(OFF_MCW, 32'h0000_0100);
        rd(OFF_STATUS); chk(d[31:16], 32'h0000_0004);
        chk(32'(d[3]), 32'h0000_0001);
        wr(OFF_PERIOD, 32'h0000_003c);
        wr(OFF_MCW, 32'h0000_0140);
        rd(OFF_STATUS); chk(d[31:16], 32'h0000_0004);
        // Precharge end applies each legal multiple in turn
        for (int k = 2; k <= 5; k++) begin
            wr(OFF_MCW, 32'(k) << 6);
            wr(OFF_MODE, 32'h0000_0002);
            rd(OFF_STATUS); chk(d[31:16], 32'(60 / k));
        end
        wr(8'h40, 32'h0000_0001);
        chk(32'(r), 32'(RESP_SLVERR));
        rd(8'h40); chk(32'(r), 32'(RESP_SLVERR));
    endtask
    // Period 12, duty 4: four on-cycles and one sample per period
    task automatic t_pwm;
        wr(OFF_DUTY, 32'h0000_0004);
        wr(OFF_MODE, 32'h0000_0004);
        repeat (30) @(posedge clk);
        tally(24);
        chk(32'(ns), 32'h0000_0002);
        chk(32'(np), 32'h0000_0008);
        chk(32'(nt), 32'h0000_0002);
        // Full duty written just after a strobe must not act before the next one
        do @(posedge clk); while (!loop_start);
        wr(OFF_DUTY, 32'h0000_000c);
        tally(6);
        chk(32'(np), 32'h0000_0000);
        wr(OFF_DUTY, 32'h0000_0000);
        repeat (30) @(posedge clk);
        tally(24); chk(32'(np), 32'h0000_0000);
    endtask
    task automatic t_ref;
        wr(OFF_HYST, 32'h0000_0005);
        ac_peak <= 16'h0064;
        wr(OFF_MODE, 32'h0000_0005);
        repeat (60) @(posedge clk);
        chk(32'(dc_bus_ref), 32'h0000_005f);
        wr(OFF_VREF, 32'h0000_0123);
        wr(OFF_MODE, 32'h0000_0004);
        repeat (3) @(posedge clk);
        chk(32'(dc_bus_ref), 32'h0000_0123);
    endtask
    task automatic t_kill;
        wr(OFF_DUTY, 32'h0000_000c);
        repeat (30) @(posedge clk);
        tally(24);
        chk(32'(np), 32'h0000_0018);
        gatekill_in <= 1'b1;
        repeat (6) @(posedge clk);
        tally(24); chk(32'(np), 32'h0000_0000);
        rd(OFF_STATUS);
        chk(32'(d[1:0]), 32'h0000_0003);
    endtask
    task automatic final_report;
        if (bad_count == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_rate; t_pwm; t_ref; t_kill;
        final_report;
    end
    initial begin
        #200000;
        bad_count++;
        final_report;
    end
endmodule
`default_nettype wire
